// ==== core/otp_config_and_host_commands.v ====
// configuration loader and host command logic of a battery monitor:
// two one-time images merged with defaults at power-up, subcommand
// handshake, transfer buffer, latched alarms and pin setup decode.
// assumes the command port is driven by a decoder on the same clock.
//
// Notes on behaviour
// RL1: two one-time images, all zero initially
// RL2: setting equals image0 xor image1 xor default
// RL3: bits program once; second image restores default
// RL4: eight signatures; no programming afterwards
// RL5: alarm function drives pin; flags stay latched
// RL6: alarm write clears ones, keeps zeros
// RL7: results appear after about 500us execution
// RL8: code reads back only when results ready
// RL9: host may wait 2ms instead
// RL10: host checks security bits equal 01
// RL11: enter update mode with 0x0090 first
// RL12: leave update mode with 0x0092
// RL13: pull-up field selects 18k, 180k, none
// RL14: polynomial field selects model or raw
// RL15: measurement type field selects usage
// RL16: pin function field selects pin use
// RL17: up to nine temperature inputs
// RL18: dedicated pin: 00 skips, 11 measures
// RL19: sixteen cell gains, pack gain, offset
// RL20: temperature protections disableable, range limited
// RL21: finish loading before accepting host commands
`timescale 1ns/1ps
`default_nettype none
`include "otp_cfg_defines.vh"

module otp_config_and_host_commands #(
    parameter EXEC_CYCLES = `EXEC_TIME_US * `CLK_MHZ   // subcommand run time
) (
    input  wire          i_ref_clk,          // device clock
    input  wire          i_rst,              // power-on reset, async, high
    input  wire          i_ce,               // clock enable, freezes state
    input  wire  [7:0]   i_cmd_addr,         // direct command offset
    input  wire          i_cmd_wr,           // write strobe
    input  wire          i_cmd_rd,           // read strobe
    input  wire  [7:0]   i_cmd_wdata,        // write byte
    output reg   [7:0]   o_cmd_rdata,        // read byte
    output reg           o_cmd_rvalid,       // read answer pulse
    output wire          o_cmd_ready,        // loading done, port open
    input  wire          i_security_state_hi,// security bit 1
    input  wire          i_security_state_lo,// security bit 0
    input  wire  [15:0]  i_alarm_events,     // alarm set pulses
    output reg           o_alert,            // alert pin level
    output reg           o_cfg_update,       // update mode active
    output wire  [17:0]  o_pin_pull_flat,    // pull-up select per pin
    output wire  [17:0]  o_pin_poly_flat,    // polynomial per pin
    output wire  [17:0]  o_pin_meas_flat,    // measurement type per pin
    output wire  [8:0]   o_temp_input_en,    // pin measured as temperature
    output wire  [8:0]   o_cell_prot_en,     // pin feeds cell protection
    output wire  [8:0]   o_fet_prot_en,      // pin feeds switch protection
    output wire  [8:0]   o_gpo_en,           // pin is digital output
    output wire  [8:0]   o_alt_en,           // pin uses alternate function
    output reg           o_ot_enable,        // over-temperature enabled
    output reg           o_ut_enable,        // under-temperature enabled
    output reg   [7:0]   o_ot_limit,         // over-temp trigger, signed C
    output reg   [7:0]   o_ut_limit,         // under-temp trigger, signed C
    input  wire  [15:0]  i_cell_raw,         // raw cell reading
    input  wire  [3:0]   i_cell_idx,         // which cell it belongs to
    input  wire  [15:0]  i_pack_raw,         // raw pack reading
    output reg   [15:0]  o_cell_volt,        // calibrated cell reading
    output reg   [15:0]  o_pack_volt         // calibrated pack reading
);
    // one-hot states of the command engine
    localparam [2:0] ST_LOAD = 3'b001;   // merging images into settings
    localparam [2:0] ST_IDLE = 3'b010;   // waiting for host
    localparam [2:0] ST_EXEC = 3'b100;   // subcommand running

    reg  [2:0]  state;                   // engine state
    reg  [2:0]  next_state;              // engine next state
    reg  [7:0]  otp0 [0:`CFG_DEPTH-1];   // first one-time image
    reg  [7:0]  otp1 [0:`CFG_DEPTH-1];   // second one-time image
    reg  [7:0]  cfg  [0:`CFG_DEPTH-1];   // live settings
    reg  [7:0]  xbuf [0:`XFER_DEPTH-1];  // transfer buffer
    reg  [4:0]  load_idx;                // loader position
    reg  [7:0]  code_lo;                 // subcommand low byte
    reg  [15:0] code;                    // latched subcommand
    reg  [15:0] exec_cnt;                // execution countdown
    reg  [3:0]  sig_used;                // signatures spent
    reg  [15:0] alarm_flags;             // latched alarms
    reg  [15:0] alarm_clr;               // clear mask this cycle
    integer     k;                       // loop index

    wire        busy;                    // subcommand not finished
    wire        is_xfer;                 // address hits the buffer
    wire [4:0]  xidx;                    // buffer index
    wire [4:0]  gain_idx;                // settings index of cell gain
    wire [4:0]  prog_addr;               // programming target byte
    wire [7:0]  alert_setup;             // alert pin setup byte

    // RL21 port opens only after loading
    assign o_cmd_ready = !state[0];
    assign busy        = state[2];
    assign is_xfer     = (i_cmd_addr[7:5] == `XFER_TAG);
    assign xidx        = i_cmd_addr[4:0];
    assign gain_idx    = `CFG_CELL_GAIN + {1'b0, i_cell_idx};
    assign prog_addr   = xbuf[1][4:0];
    assign alert_setup = cfg[`CFG_ALERT_PIN];

    // built-in default for each settings byte
    function [7:0] dflt;
        input [4:0] idx;
        begin
            case (idx)
                `CFG_PROT_EN:  dflt = `DFLT_PROT_EN;
                `CFG_OT_LIMIT: dflt = `DFLT_OT_LIMIT;
                `CFG_UT_LIMIT: dflt = `DFLT_UT_LIMIT;
                default:       dflt = `DFLT_PIN;
            endcase
        end
    endfunction

    // keep a signed temperature inside the programmable range
    function [7:0] clamp_temp;
        input [7:0] t;
        begin
            if ($signed(t) < $signed(`TEMP_MIN)) begin
                clamp_temp = `TEMP_MIN;
            end else if ($signed(t) > $signed(`TEMP_MAX)) begin
                clamp_temp = `TEMP_MAX;
            end else begin
                clamp_temp = t;
            end
        end
    endfunction

    // next state of the command engine
    always @* begin
        next_state = state;
        case (state)
            ST_LOAD: begin
                if (load_idx == `CFG_DEPTH - 1) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // a write of the high code byte starts execution
                if (i_cmd_wr && i_cmd_addr == `OFS_SUBCMD_HI) begin
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (exec_cnt == 16'h0000) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_LOAD;
        endcase
    end

    // images, settings, buffer and subcommand execution
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state        <= ST_LOAD;
            load_idx     <= 5'h00;
            code_lo      <= 8'h00;
            code         <= 16'h0000;
            exec_cnt     <= 16'h0000;
            sig_used     <= 4'h0;
            o_cfg_update <= 1'b0;
            for (k = 0; k < `CFG_DEPTH; k = k + 1) begin
                // RL1 images start blank
                otp0[k] <= 8'h00;
                otp1[k] <= 8'h00;
                cfg[k]  <= 8'h00;
                xbuf[k] <= 8'h00;
            end
        end else if (i_ce) begin
            state <= next_state;
            case (state)
                ST_LOAD: begin
                    // RL2 merge both images with default
                    cfg[load_idx] <= otp0[load_idx] ^ otp1[load_idx] ^ dflt(load_idx);
                    load_idx      <= load_idx + 5'h01;
                end
                ST_IDLE: begin
                    if (i_cmd_wr) begin
                        if (i_cmd_addr == `OFS_SUBCMD_LO) begin
                            code_lo <= i_cmd_wdata;
                        end else if (i_cmd_addr == `OFS_SUBCMD_HI) begin
                            // RL7 hold results back for the run time
                            code     <= {i_cmd_wdata, code_lo};
                            exec_cnt <= EXEC_CYCLES[15:0] - 16'h0001;
                        end else if (is_xfer) begin
                            xbuf[xidx] <= i_cmd_wdata;
                        end
                    end
                end
                ST_EXEC: begin
                    if (exec_cnt != 16'h0000) begin
                        exec_cnt <= exec_cnt - 16'h0001;
                    end else begin
                        case (code)
                            // RL11 enter update mode
                            `SUB_ENTER_CFG: o_cfg_update <= 1'b1;
                            // RL12 leave update mode
                            `SUB_EXIT_CFG: o_cfg_update <= 1'b0;
                            `SUB_READ_CFG: begin
                                for (k = 0; k < `CFG_DEPTH; k = k + 1) begin
                                    xbuf[k] <= cfg[k];
                                end
                            end
                            `SUB_WRITE_CFG: begin
                                // RL11 changes only in update mode
                                if (o_cfg_update) begin
                                    for (k = 0; k < `CFG_DEPTH; k = k + 1) begin
                                        cfg[k] <= xbuf[k];
                                    end
                                end
                            end
                            `SUB_OTP_PROG: begin
                                // RL4 a pass needs a free signature
                                if (o_cfg_update && sig_used < `OTP_SIGNATURES) begin
                                    sig_used <= sig_used + 4'h1;
                                    xbuf[0]  <= 8'h01;
                                    // RL3 bits only ever go from 0 to 1
                                    if (xbuf[0][0]) begin
                                        otp1[prog_addr] <= otp1[prog_addr] | xbuf[2];
                                    end else begin
                                        otp0[prog_addr] <= otp0[prog_addr] | xbuf[2];
                                    end
                                end else begin
                                    xbuf[0] <= 8'h00;
                                end
                            end
                            // unknown codes simply complete
                            default: code <= code;
                        endcase
                    end
                end
                default: load_idx <= 5'h00;
            endcase
        end
    end

    // clear mask from host writes to the alarm pair
    always @* begin
        alarm_clr = 16'h0000;
        if (i_cmd_wr && o_cmd_ready) begin
            if (i_cmd_addr == `OFS_ALARM_LO) begin
                alarm_clr[7:0] = i_cmd_wdata;
            end else if (i_cmd_addr == `OFS_ALARM_HI) begin
                alarm_clr[15:8] = i_cmd_wdata;
            end
        end
    end

    // latched alarms; a new event beats a clear in the same cycle
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            alarm_flags <= 16'h0000;
            o_alert     <= 1'b0;
        end else if (i_ce) begin
            // RL6 ones clear, zeros keep
            alarm_flags <= (alarm_flags & ~alarm_clr) | i_alarm_events;
            // RL5 pin follows flags in alarm function
            o_alert <= (alert_setup[`PIN_FUNCTION_SELECT_LSB+1:`PIN_FUNCTION_SELECT_LSB] == `FXN_ALT) &&
                       (alarm_flags != 16'h0000);
        end
    end

    // read answers, one cycle after the strobe
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cmd_rdata  <= 8'h00;
            o_cmd_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_cmd_rvalid <= i_cmd_rd && o_cmd_ready;
            if (i_cmd_rd && o_cmd_ready) begin
                if (i_cmd_addr == `OFS_BATT_STATE_LO) begin
                    o_cmd_rdata <= {6'h00, busy, o_cfg_update};
                end else if (i_cmd_addr == `OFS_BATT_STATE_HI) begin
                    // RL10 security pair for the host to check
                    o_cmd_rdata <= {6'h00, i_security_state_hi, i_security_state_lo};
                end else if (i_cmd_addr == `OFS_SUBCMD_LO) begin
                    // RL8 code returns only when complete
                    o_cmd_rdata <= busy ? `SUBCMD_BUSY_BYTE : code[7:0];
                end else if (i_cmd_addr == `OFS_SUBCMD_HI) begin
                    o_cmd_rdata <= busy ? `SUBCMD_BUSY_BYTE : code[15:8];
                end else if (is_xfer) begin
                    o_cmd_rdata <= xbuf[xidx];
                end else if (i_cmd_addr == `OFS_ALARM_LO) begin
                    o_cmd_rdata <= alarm_flags[7:0];
                end else if (i_cmd_addr == `OFS_ALARM_HI) begin
                    o_cmd_rdata <= alarm_flags[15:8];
                end else begin
                    o_cmd_rdata <= 8'h00;
                end
            end
        end
    end

    // RL17 nine pins, each decoded alike
    genvar g;
    generate
        for (g = 0; g < `CFG_PINS; g = g + 1) begin : pin_dec
            pin_setup_decode u_dec (
                .i_setup      (cfg[g]),
                .o_pull_sel   (o_pin_pull_flat[2*g+1:2*g]),
                .o_poly_sel   (o_pin_poly_flat[2*g+1:2*g]),
                .o_meas_type  (o_pin_meas_flat[2*g+1:2*g]),
                .o_temp_input (o_temp_input_en[g]),
                .o_cell_prot  (o_cell_prot_en[g]),
                .o_fet_prot   (o_fet_prot_en[g]),
                .o_gpo        (o_gpo_en[g]),
                .o_alt        (o_alt_en[g])
            );
        end
    endgenerate

    // calibrated readings: raw plus raw*gain/256, plus offset for the cell reading only
    reg signed [25:0] cell_calc;          // cell result before trimming
    reg signed [25:0] pack_calc;          // pack result before trimming
    reg [7:0]         cell_gain;          // gain of the selected cell
    always @* begin
        cell_gain = cfg[gain_idx];
        cell_calc = $signed({10'h000, i_cell_raw})
                  + (($signed({10'h000, i_cell_raw}) * $signed(cell_gain)) >>> 8)
                  + $signed(cfg[`CFG_CELL_OFFSET]);
        pack_calc = $signed({10'h000, i_pack_raw})
                  + (($signed({10'h000, i_pack_raw}) * $signed(cfg[`CFG_PACK_GAIN])) >>> 8);
    end

    // registered calibration and protection outputs
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cell_volt <= 16'h0000;
            o_pack_volt <= 16'h0000;
            o_ot_enable <= 1'b0;
            o_ut_enable <= 1'b0;
            o_ot_limit  <= 8'h00;
            o_ut_limit  <= 8'h00;
        end else if (i_ce) begin
            // RL19 per-cell gain, pack gain, offset
            o_cell_volt <= cell_calc[15:0];
            o_pack_volt <= pack_calc[15:0];
            // RL20 enables and clamped trigger points
            o_ot_enable <= cfg[`CFG_PROT_EN][`PROT_OT_BIT];
            o_ut_enable <= cfg[`CFG_PROT_EN][`PROT_UT_BIT];
            o_ot_limit  <= clamp_temp(cfg[`CFG_OT_LIMIT]);
            o_ut_limit  <= clamp_temp(cfg[`CFG_UT_LIMIT]);
        end
    end

endmodule // otp_config_and_host_commands
`default_nettype wire

// ==== core/otp_cfg_defines.vh ====
// constants for the configuration loader and host command block:
// direct command offsets, settings layout, subcommand codes, field
// positions, default values and timing. definitions only.
`ifndef OTP_CFG_DEFINES_VH
`define OTP_CFG_DEFINES_VH

// clock rate and subcommand execution time
`define CLK_MHZ            100
`define EXEC_TIME_US       500

// direct command offsets (byte addresses of the command port)
`define OFS_BATT_STATE_LO  8'h12
`define OFS_BATT_STATE_HI  8'h13
`define OFS_SUBCMD_LO      8'h3E
`define OFS_SUBCMD_HI      8'h3F
`define OFS_XFER_BUF       8'h40
`define OFS_ALARM_LO       8'h62
`define OFS_ALARM_HI       8'h63

// transfer buffer decode: 0x40..0x5F
`define XFER_TAG           3'h2
`define XFER_DEPTH         32

// readback while a subcommand still executes
`define SUBCMD_BUSY_BYTE   8'hFF

// subcommand codes
`define SUB_ENTER_CFG      16'h0090
`define SUB_EXIT_CFG       16'h0092
`define SUB_OTP_PROG       16'h00A0
`define SUB_READ_CFG       16'h00A1
`define SUB_WRITE_CFG      16'h00A2

// settings image layout (byte index)
`define CFG_DEPTH          32
`define CFG_PINS           9
`define CFG_ALERT_PIN      5
`define CFG_PROT_EN        5'h09
`define CFG_OT_LIMIT       5'h0A
`define CFG_UT_LIMIT       5'h0B
`define CFG_CELL_GAIN      5'h0C
`define CFG_PACK_GAIN      5'h1C
`define CFG_CELL_OFFSET    5'h1D
`define PROT_OT_BIT        0
`define PROT_UT_BIT        1

// pin setup fields
`define PIN_FUNCTION_SELECT_LSB        0
`define PIN_MEAS_LSB       2
`define PIN_POLY_LSB       4
`define PIN_PULL_LSB       6
`define FXN_COMM           2'h0
`define FXN_GPO            2'h1
`define FXN_ALT            2'h2
`define FXN_ANALOG         2'h3
`define MEAS_ADC           2'h0
`define MEAS_CELL_PROT     2'h1
`define MEAS_FET_PROT      2'h3

// built-in defaults
`define DFLT_PIN           8'h00
`define DFLT_PROT_EN       8'h03
`define DFLT_OT_LIMIT      8'h37
`define DFLT_UT_LIMIT      8'h00
`define DFLT_GAIN          8'h00

// temperature range in degrees C (signed byte)
`define TEMP_MIN           8'hD8
`define TEMP_MAX           8'h78

// one signature is spent per programming pass
`define OTP_SIGNATURES     4'h8

`endif

// ==== core/pin_setup_decode.v ====
// decodes one multipurpose pin setup byte into its pin function,
// pull-up, polynomial and measurement selections.
// assumes the byte is a settled settings register on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "otp_cfg_defines.vh"

module pin_setup_decode (
    input  wire [7:0] i_setup,        // pin setup byte
    output wire [1:0] o_pull_sel,     // 00 18k, 01 180k, 10 none
    output wire [1:0] o_poly_sel,     // 00 first, 01 second, 10 custom, 11 raw
    output wire [1:0] o_meas_type,    // measurement type
    output wire       o_temp_input,   // pin is measured as temperature
    output wire       o_cell_prot,    // feeds cell temperature protection
    output wire       o_fet_prot,     // feeds switch temperature protection
    output wire       o_gpo,          // digital output function
    output wire       o_alt           // alternate function
);
    wire [1:0] pin_function_select;   // function field
    wire [5:0] pin_option_bits;       // option field

    assign pin_function_select = i_setup[`PIN_FUNCTION_SELECT_LSB+1:`PIN_FUNCTION_SELECT_LSB];
    assign pin_option_bits     = i_setup[7:`PIN_MEAS_LSB];

    // RL13 pull-up selection
    assign o_pull_sel  = i_setup[`PIN_PULL_LSB+1:`PIN_PULL_LSB];
    // RL14 polynomial choice
    assign o_poly_sel  = pin_option_bits[3:2];
    // RL15 measurement type
    assign o_meas_type = pin_option_bits[1:0];
    // RL16 function field decode
    assign o_gpo       = (pin_function_select == `FXN_GPO);
    assign o_alt       = (pin_function_select == `FXN_ALT);
    // RL18 only function 11 measures; 00 skips
    assign o_temp_input = (pin_function_select == `FXN_ANALOG) &&
                          (o_meas_type != `MEAS_ADC);
    assign o_cell_prot  = o_temp_input && (o_meas_type == `MEAS_CELL_PROT);
    assign o_fet_prot   = o_temp_input && (o_meas_type == `MEAS_FET_PROT);

endmodule // pin_setup_decode
`default_nettype wire

// ==== testbench/otp_cfg_props.sv ====
// checker: command port, alert pin, pin decode
// bound to the top module; i_ce high
`timescale 1ns/1ps
`default_nettype none
module otp_cfg_props (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_cmd_rd,
    input wire logic        i_cmd_wr,
    input wire logic        o_cmd_rvalid,
    input wire logic        o_cmd_ready,
    input wire logic        o_alert,
    input wire logic [8:0]  o_alt_en,
    input wire logic [8:0]  o_gpo_en,
    input wire logic [8:0]  o_temp_input_en,
    input wire logic [8:0]  o_cell_prot_en,
    input wire logic [8:0]  o_fet_prot_en,
    input wire logic [17:0] o_pin_meas_flat,
    input wire logic [7:0]  o_ot_limit
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    property p_read_answer; (i_cmd_rd && o_cmd_ready) |=> o_cmd_rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("no answer");
    property p_refused; (i_cmd_rd && !o_cmd_ready) |=> !o_cmd_rvalid; endproperty
    a_refused: assert property (p_refused) else $error("early answer");
    property p_ready_holds; o_cmd_ready |=> o_cmd_ready; endproperty
    a_ready_holds: assert property (p_ready_holds) else $error("ready dropped");
    property p_alert_fxn; o_alert |-> $past(o_alt_en[5]); endproperty
    a_alert_fxn: assert property (p_alert_fxn) else $error("alert not alarm");
    property p_alert_holds;
    (o_alert && o_alt_en[5] && !i_cmd_wr && !$past(i_cmd_wr)) |=> o_alert; endproperty
    a_alert_holds: assert property (p_alert_holds) else $error("alert fell");
    property p_temp_pin;
        o_temp_input_en[0] |-> (o_pin_meas_flat[1:0] != 2'h0 && !o_gpo_en[0] && !o_alt_en[0]);
    endproperty
    a_temp_pin: assert property (p_temp_pin) else $error("temp decode");
    property p_cell_prot; o_cell_prot_en[0] |-> o_pin_meas_flat[1:0] == 2'h1; endproperty
    a_cell_prot: assert property (p_cell_prot) else $error("cell decode");
    property p_fet_prot; o_fet_prot_en[0] |-> o_pin_meas_flat[1:0] == 2'h3; endproperty
    a_fet_prot: assert property (p_fet_prot) else $error("fet decode");
    property p_ot_range;
        o_cmd_ready |=> ($signed(o_ot_limit) >= -8'sd40 && $signed(o_ot_limit) <= 8'sd120);
    endproperty
    a_ot_range: assert property (p_ot_range) else $error("limit range");
endmodule // otp_cfg_props
bind otp_config_and_host_commands otp_cfg_props i_otp_cfg_props (.i_ref_clk, .i_rst,
    .i_cmd_rd, .i_cmd_wr, .o_cmd_rvalid, .o_cmd_ready, .o_alert, .o_alt_en, .o_gpo_en,
    .o_temp_input_en, .o_cell_prot_en, .o_fet_prot_en, .o_pin_meas_flat, .o_ot_limit);
`default_nettype wire

// ==== testbench/host_model.sv ====
// host model: one-cycle strobes
// port samples on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_rdata,
    output var  logic [7:0] o_addr,
    output var  logic [7:0] o_wdata,
    output var  logic       o_wr,
    output var  logic       o_rd
);
    int gap = 0; // idle cycles per access
    initial {o_addr, o_wdata, o_wr, o_rd} = 18'h00000;
    // one access; idle bus scrambled
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        repeat (gap) @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        {o_addr, o_wdata, o_wr, o_rd} <= {a, d, w, !w};
        @(posedge i_ref_clk);
        {o_addr, o_wdata, o_wr, o_rd} <= {~a, ~d, 2'b00};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        @(posedge i_ref_clk);
        d = i_rdata;
    endtask
    task automatic sub(input logic [15:0] c, output logic [7:0] first);
        logic [7:0] lo, hi;
        acc(1'b1, 8'h3E, c[7:0]);
        acc(1'b1, 8'h3F, c[15:8]);
        rd(8'h3E, first);
        for (int n = 0; n < 60; n++) begin
            rd(8'h3E, lo);
            rd(8'h3F, hi);
            if ({hi, lo} === c) break;
        end
    endtask
endmodule // host_model
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the config loader
// host model owns the port; i_ce tied high
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0, rst = 1'b1, sec_hi = 1'b0, sec_lo = 1'b1;
    logic [15:0] events = 16'h0000, craw = 16'h0100, praw = 16'h0200, cvolt, pvolt;
    logic [7:0]  addr, wdata, rdata, d, first, otl, utl, cfg [0:31];
    logic        wr, rd, rvalid, ready, alert, upd, ote, ute;
    logic [17:0] pull, poly, meas;
    logic [8:0]  tin, cpe, fpe, digital_output_function, alternate_function;
    int          errors = 0, samples_checked = 0;
    // setup byte, then pull, poly, meas, temp, cell, fet, gpo, alt
    logic [18:0] rows [0:5] = '{19'h03838, 19'h2FAF4, 19'h55D50, 19'h18982, 19'h01001, 19'h01800};
    otp_config_and_host_commands #(.EXEC_CYCLES(20)) i_otp_config_and_host_commands (
        .i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_cmd_addr(addr), .i_cmd_wr(wr),
        .i_cmd_rd(rd), .i_cmd_wdata(wdata), .o_cmd_rdata(rdata), .o_cmd_rvalid(rvalid),
        .o_cmd_ready(ready), .i_security_state_hi(sec_hi), .i_security_state_lo(sec_lo),
        .i_alarm_events(events), .o_alert(alert), .o_cfg_update(upd), .o_pin_pull_flat(pull),
        .o_pin_poly_flat(poly), .o_pin_meas_flat(meas), .o_temp_input_en(tin),
        .o_cell_prot_en(cpe), .o_fet_prot_en(fpe), .o_gpo_en(digital_output_function), .o_alt_en(alternate_function),
        .o_ot_enable(ote), .o_ut_enable(ute), .o_ot_limit(otl), .o_ut_limit(utl),
        .i_cell_raw(craw), .i_cell_idx(4'h3), .i_pack_raw(praw), .o_cell_volt(cvolt),
        .o_pack_volt(pvolt));
    host_model i_host_model (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // settings via buffer
    task automatic load;
        for (int i = 0; i < 32; i++) i_host_model.acc(1'b1, 8'h40 + 8'(i), cfg[i]);
        i_host_model.sub(16'h00A2, first);
    endtask
    // hang guard
    initial begin
        #300000;
        errors++;
        test_done();
    end
    initial begin
        foreach (cfg[i]) cfg[i] = 8'h00;
        cfg[9] = 8'h03;
        cfg[10] = 8'h37;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        i_host_model.rd(8'h13, d);
        chk(16'(ready), 16'h0000);
        for (int n = 0; n < 40 && !ready; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk({otl, utl}, 16'h3700);
        chk(16'({ote, ute, upd}), 16'h0006);
        i_host_model.rd(8'h13, d);
        chk(16'(d), 16'h0001);
        i_host_model.sub(16'h0090, first);
        chk(16'(first), 16'h00FF);
        i_host_model.rd(8'h12, d);
        chk(16'({d, 7'h00, upd}), 16'h0101);
        foreach (rows[r]) begin
            cfg[0] = rows[r][18:11];
            load();
            chk(16'({pull[1:0], poly[1:0], meas[1:0], tin[0], cpe[0], fpe[0], digital_output_function[0], alternate_function[0]}),
                16'(rows[r][10:0]));
        end
        cfg[5] = 8'h02;
        cfg[9] = 8'h00;
        cfg[10] = 8'h7F;
        cfg[11] = 8'hC0;
        cfg[15] = 8'h40;
        cfg[28] = 8'h80;
        cfg[29] = 8'h02;
        load();
        chk({otl, utl}, 16'h78D8);
        chk(16'({ote, ute}), 16'h0000);
        chk(cvolt, 16'h0142);
        chk(pvolt, 16'h0100);
        events <= 16'h0005;
        @(posedge clk);
        events <= 16'h0000;
        i_host_model.acc(1'b1, 8'h62, 8'h01);
        i_host_model.rd(8'h62, d);
        chk({d, 7'h00, alert}, 16'h0401);
        i_host_model.acc(1'b1, 8'h62, 8'h04);
        i_host_model.rd(8'h62, d);
        chk({d, 7'h00, alert}, 16'h0000);
        i_host_model.sub(16'h0092, first);
        i_host_model.sub(16'h00A1, first);
        i_host_model.rd(8'h45, d);
        chk({d, 7'h00, upd}, 16'h0200);
        i_host_model.sub(16'h0090, first);
        i_host_model.gap = 2;
        for (int k = 0; k < 9; k++) begin
            i_host_model.acc(1'b1, 8'h40, 8'h00);
            i_host_model.acc(1'b1, 8'h41, 8'(k));
            i_host_model.acc(1'b1, 8'h42, 8'h01);
            i_host_model.sub(16'h00A0, first);
            i_host_model.rd(8'h40, d);
            chk(16'(d), (k < 8) ? 16'h0001 : 16'h0000);
        end
        test_done();
    end
endmodule // tb
`default_nettype wire
